// [bzm_top.sv]
// buzzer and melody tone generator with avalon-mm register slave.
// assumes one 20 MHz clock; the bus address is the register index.
//
// Functional notes
// - tone is clock / base / (pitch + 1)
// - base is 32, or 64 when selected
// - tone lasts time unit times length
// - silent gap lasts time unit times gap
// - time unit field selects 1/2/4/8 ms
// - any note start restarts window timer
// - window expiry sets sticky flag, optional interrupt
// - enabled note end sets flag, write 0 clears
// - writing one starts note, zero ignored
// - start bit self clears after note completes
// - both started together: A then B
// - busy bits read where start bits written
// - play once in sequence or ping-pong
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/10ps
`include "bzm_params.svh"
module bzm_top import bzm_pkg::*; #(
  parameter int CYC_PER_MS = `BZM_CYC_PER_MS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // avalon-mm slave
  input wire logic [15:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // buzzer side
  output logic beeper_pin_o,
  output logic drive_window_o,
  // interrupt
  output logic irq_o
);

  // ==========================================================
  // declarations
  logic ack_q, ack_d;
  logic [7:0] rdata_q, rdata_d;
  logic wr_en;
  logic [7:0] wd;
  logic [11:0] pitch_a_q, pitch_a_d, pitch_b_q, pitch_b_d;
  logic [7:0] len_a_q, len_a_d, len_b_q, len_b_d;
  logic [7:0] gap_a_q, gap_a_d, gap_b_q, gap_b_d;
  logic [7:0] win_len_q, win_len_d;
  logic en_q, en_d, pol_q, pol_d, iena_q, iena_d, ienb_q, ienb_d;
  logic flga_q, flga_d, flgb_q, flgb_d, cmda_q, cmda_d, cmdb_q, cmdb_d;
  logic [1:0] tu_q, tu_d;
  logic tone_base_select_q, tone_base_select_d, wien_q, wien_d, wflg_q, wflg_d, pp_q, pp_d;
  logic [2:0] sts_q, sts_d, msk_q, msk_d, sts_set;
  bzm_state_e st_q, st_d;
  logic sel_q, sel_d;
  logic [7:0] cnt_q, cnt_d, win_cnt_q, win_cnt_d;
  logic win_run_q, win_run_d;
  logic pin_q, pin_d;
  logic tick, wave, launch, done, win_exp;
  logic [7:0] cur_len, cur_gap;
  logic busy_a, busy_b;

  // ==========================================================
  // helpers
  function automatic logic hit(input logic [15:0] a, input logic [15:0] idx);
    hit = (a == idx);
  endfunction : hit

  // a hardware set wins over a software clear in the same cycle
  function automatic logic flag_upd(input logic set, input logic cur, input logic clr);
    flag_upd = set | (cur & ~clr);
  endfunction : flag_upd

  // ==========================================================
  // bus slave: one wait state, then write lands and read data stand
  always_comb begin
    ack_d = (avs_read_i | avs_write_i) & ~ack_q;
    rdata_d = rdata_q;
    if (avs_read_i & ~ack_q) begin
      unique case (avs_address_i)
        `BZM_IDX_A_PITCH_LO: rdata_d = pitch_a_q[7:0];
        `BZM_IDX_A_PITCH_HI: rdata_d = {4'h0, pitch_a_q[11:8]};
        `BZM_IDX_A_LENGTH: rdata_d = len_a_q;
        `BZM_IDX_A_GAP: rdata_d = gap_a_q;
        `BZM_IDX_B_PITCH_LO: rdata_d = pitch_b_q[7:0];
        `BZM_IDX_B_PITCH_HI: rdata_d = {4'h0, pitch_b_q[11:8]};
        `BZM_IDX_B_LENGTH: rdata_d = len_b_q;
        `BZM_IDX_B_GAP: rdata_d = gap_b_q;
        `BZM_IDX_CONFIG: rdata_d = {en_q, pol_q, ienb_q, iena_q, flgb_q, flga_q,
                                    busy_b, busy_a};
        `BZM_IDX_WIN_LENGTH: rdata_d = win_len_q;
        `BZM_IDX_TIMEBASE: rdata_d = {tu_q, 1'b0, tone_base_select_q, 2'b00, wien_q, wflg_q};
        `BZM_IDX_MELODY_CTRL: rdata_d = {7'h00, pp_q};
        `BZM_IDX_IRQ_STATUS: rdata_d = {5'h00, sts_q};
        `BZM_IDX_IRQ_MASK: rdata_d = {5'h00, msk_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
  assign avs_readdata_o = {24'h000000, rdata_q};
  assign wr_en = avs_write_i & ack_q;
  assign wd = avs_writedata_i[7:0];
  assign busy_a = (st_q != BZM_IDLE) & ~sel_q;
  assign busy_b = (st_q != BZM_IDLE) & sel_q;

  // ==========================================================
  // registers written by software, with hardware set and clear
  always_comb begin
    pitch_a_d = pitch_a_q;
    pitch_b_d = pitch_b_q;
    len_a_d = len_a_q;
    len_b_d = len_b_q;
    gap_a_d = gap_a_q;
    gap_b_d = gap_b_q;
    win_len_d = win_len_q;
    en_d = en_q;
    pol_d = pol_q;
    iena_d = iena_q;
    ienb_d = ienb_q;
    tu_d = tu_q;
    tone_base_select_d = tone_base_select_q;
    wien_d = wien_q;
    pp_d = pp_q;
    msk_d = msk_q;
    if (wr_en) begin
      unique case (avs_address_i)
        `BZM_IDX_A_PITCH_LO: pitch_a_d[7:0] = wd;
        `BZM_IDX_A_PITCH_HI: pitch_a_d[11:8] = wd[3:0];
        `BZM_IDX_A_LENGTH: len_a_d = wd;
        `BZM_IDX_A_GAP: gap_a_d = wd;
        `BZM_IDX_B_PITCH_LO: pitch_b_d[7:0] = wd;
        `BZM_IDX_B_PITCH_HI: pitch_b_d[11:8] = wd[3:0];
        `BZM_IDX_B_LENGTH: len_b_d = wd;
        `BZM_IDX_B_GAP: gap_b_d = wd;
        `BZM_IDX_CONFIG: begin
          en_d = wd[`BZM_CFG_EN];
          pol_d = wd[`BZM_CFG_POL];
          ienb_d = wd[`BZM_CFG_IENB];
          iena_d = wd[`BZM_CFG_IENA];
        end
        `BZM_IDX_WIN_LENGTH: win_len_d = wd;
        `BZM_IDX_TIMEBASE: begin
          tu_d = wd[`BZM_TB_TU_HI:`BZM_TB_TU_LO];
          tone_base_select_d = wd[`BZM_TB_BASE];
          wien_d = wd[`BZM_TB_WIEN];
        end
        `BZM_IDX_MELODY_CTRL: pp_d = wd[`BZM_MC_PINGPONG];
        `BZM_IDX_IRQ_MASK: msk_d = wd[2:0];
        default: ;
      endcase
    end
    // start bits: only a written one acts, completion clears them
    cmda_d = en_d & (((wr_en & hit(avs_address_i, `BZM_IDX_CONFIG) & wd[`BZM_CFG_CMDA])
             | (launch & ~sel_d)) | (cmda_q & ~(done & ~sel_q)));
    cmdb_d = en_d & (((wr_en & hit(avs_address_i, `BZM_IDX_CONFIG) & wd[`BZM_CFG_CMDB])
             | (launch & sel_d)) | (cmdb_q & ~(done & sel_q)));
    flga_d = flag_upd(done & ~sel_q & iena_q, flga_q,
                      wr_en & hit(avs_address_i, `BZM_IDX_CONFIG) & ~wd[`BZM_CFG_FLGA]);
    flgb_d = flag_upd(done & sel_q & ienb_q, flgb_q,
                      wr_en & hit(avs_address_i, `BZM_IDX_CONFIG) & ~wd[`BZM_CFG_FLGB]);
    wflg_d = flag_upd(win_exp, wflg_q,
                      wr_en & hit(avs_address_i, `BZM_IDX_TIMEBASE) & ~wd[`BZM_TB_WFLG]);
    sts_set = {win_exp & wien_q, done & sel_q & ienb_q, done & ~sel_q & iena_q};
    sts_d = sts_set | (sts_q & ~((wr_en & hit(avs_address_i, `BZM_IDX_IRQ_STATUS))
                                 ? wd[2:0] : 3'h0));
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pitch_a_q <= 12'h000;
      pitch_b_q <= 12'h000;
      len_a_q <= `BZM_RST_VAL;
      len_b_q <= `BZM_RST_VAL;
      gap_a_q <= `BZM_RST_VAL;
      gap_b_q <= `BZM_RST_VAL;
      win_len_q <= `BZM_RST_VAL;
      {en_q, pol_q, ienb_q, iena_q, flgb_q, flga_q, cmdb_q, cmda_q} <= `BZM_RST_VAL;
      tu_q <= 2'h0;
      tone_base_select_q <= 1'b0;
      wien_q <= 1'b0;
      wflg_q <= 1'b0;
      pp_q <= 1'b0;
      sts_q <= 3'h0;
      msk_q <= 3'h0;
    end else begin
      pitch_a_q <= pitch_a_d;
      pitch_b_q <= pitch_b_d;
      len_a_q <= len_a_d;
      len_b_q <= len_b_d;
      gap_a_q <= gap_a_d;
      gap_b_q <= gap_b_d;
      win_len_q <= win_len_d;
      {en_q, pol_q, ienb_q, iena_q, flgb_q, flga_q, cmdb_q, cmda_q} <=
        {en_d, pol_d, ienb_d, iena_d, flgb_d, flga_d, cmdb_d, cmda_d};
      tu_q <= tu_d;
      tone_base_select_q <= tone_base_select_d;
      wien_q <= wien_d;
      wflg_q <= wflg_d;
      pp_q <= pp_d;
      sts_q <= sts_d;
      msk_q <= msk_d;
    end
  end

  assign irq_o = |(sts_q & msk_q);

  // ==========================================================
  // playback sequencer
  assign cur_len = sel_q ? len_b_q : len_a_q;
  assign cur_gap = sel_q ? gap_b_q : gap_a_q;

  always_comb begin
    st_d = st_q;
    sel_d = sel_q;
    cnt_d = cnt_q;
    launch = 1'b0;
    done = 1'b0;
    if (!en_q) begin
      st_d = BZM_IDLE;
      cnt_d = 8'h00;
    end else begin
      unique case (st_q)
        BZM_IDLE: begin
          if (cmda_q | cmdb_q) begin
            launch = 1'b1;
            sel_d = ~cmda_q;
            st_d = BZM_TONE;
            cnt_d = 8'h00;
          end
        end
        BZM_TONE: begin
          if (cnt_q == cur_len) begin
            st_d = BZM_GAP;
            cnt_d = 8'h00;
          end else if (tick) begin
            cnt_d = cnt_q + 8'h01;
          end
        end
        BZM_GAP: begin
          if (cnt_q == cur_gap) begin
            done = 1'b1;
            cnt_d = 8'h00;
            // sequence: B follows A if started; ping-pong: always swap
            if (pp_q | (sel_q ? cmda_q : cmdb_q)) begin
              launch = 1'b1;
              sel_d = ~sel_q;
              st_d = BZM_TONE;
            end else begin
              st_d = BZM_IDLE;
            end
          end else if (tick) begin
            cnt_d = cnt_q + 8'h01;
          end
        end
        default: st_d = BZM_IDLE;
      endcase
    end
  end

  // ==========================================================
  // drive-window timer and pin
  always_comb begin
    win_exp = win_run_q & (win_cnt_q == win_len_q);
    win_run_d = win_run_q & ~win_exp & en_q;
    win_cnt_d = (win_run_q & tick) ? win_cnt_q + 8'h01 : win_cnt_q;
    if (launch) begin
      win_run_d = 1'b1;
      win_cnt_d = 8'h00;
    end
    pin_d = pol_q ^ (en_q & (st_q == BZM_TONE) & wave);
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q <= BZM_IDLE;
      sel_q <= 1'b0;
      cnt_q <= 8'h00;
      win_cnt_q <= 8'h00;
      win_run_q <= 1'b0;
      pin_q <= 1'b0;
    end else begin
      st_q <= st_d;
      sel_q <= sel_d;
      cnt_q <= cnt_d;
      win_cnt_q <= win_cnt_d;
      win_run_q <= win_run_d;
      pin_q <= pin_d;
    end
  end

  assign beeper_pin_o = pin_q;
  assign drive_window_o = win_run_q;

  // ==========================================================
  // sub-blocks
  bzm_tick_gen #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_tick (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .clear_i(launch | ~en_q),
    .tu_sel_i(tu_q),
    .tick_o(tick)
  );

  bzm_tone_div #(
    .PW(12)
  ) u_tone (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .run_i(en_q & (st_q == BZM_TONE)),
    .base_sel_i(tone_base_select_q),
    .pitch_i(sel_q ? pitch_b_q : pitch_a_q),
    .wave_o(wave)
  );

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  tone_length_a: assert property ((en_q && st_q == BZM_TONE && cnt_q == cur_len)
    |=> st_q == BZM_GAP && cnt_q == 8'h00) else $error("tone did not end at length");
  gap_end_a: assert property ((en_q && st_q == BZM_GAP && cnt_q == cur_gap)
    |-> done) else $error("gap end did not complete note");
  win_start_a: assert property (launch |=> win_run_q && win_cnt_q == 8'h00)
    else $error("window timer not restarted");
  // a launch in the expiry cycle restarts the timer, so it may run on
  win_flag_a: assert property (win_exp |=> wflg_q && (!win_run_q || $past(launch)))
    else $error("window flag not set on expiry");
  end_flag_a: assert property ((done && !sel_q && iena_q) |=> flga_q ##1
    (flga_q || $past(wr_en && hit(avs_address_i, `BZM_IDX_CONFIG) && !wd[`BZM_CFG_FLGA])))
    else $error("note a end flag not set");
  cmd_clear_a: assert property ((done && !sel_q && !(wr_en && wd[`BZM_CFG_CMDA]))
    |=> !cmda_q) else $error("start bit not self cleared");
  a_first_a: assert property ((en_q && st_q == BZM_IDLE && cmda_q && cmdb_q)
    |=> st_q == BZM_TONE && !sel_q) else $error("note b played before a");
  disable_idle_a: assert property (!en_q |=> st_q == BZM_IDLE
    ##1 beeper_pin_o == $past(pol_q)) else $error("disabled block still playing");
  polarity_gap_a: assert property ((st_q != BZM_TONE) |=> beeper_pin_o == $past(pol_q))
    else $error("pin not idle outside tone");
  sequence_a: assert property ((done && !sel_q && cmdb_q && en_q)
    |=> st_q == BZM_TONE && sel_q) else $error("note b did not follow a");

  pingpong_c: cover property (pp_q && done && sel_q ##1 st_q == BZM_TONE && !sel_q);
  win_exp_c: cover property (win_exp && wien_q && msk_q[`BZM_IRQ_WIN]);
  both_start_c: cover property (cmda_q && cmdb_q && st_q == BZM_IDLE);

endmodule : bzm_top

// [bzm_params.svh]
// constants of the buzzer and melody tone generator: register indexes,
// field positions, reset values and timing counts.
// assumes a single system clock; included by the top, the tick generator, the tone divider and the bench.
`ifndef BZM_PARAMS_SVH
`define BZM_PARAMS_SVH

// ==========================================================
// timing
`define BZM_CLK_PERIOD_NS 50
`define BZM_UNIT_NS 1000000
`define BZM_CYC_PER_MS (`BZM_UNIT_NS / `BZM_CLK_PERIOD_NS)
`define BZM_BASE_LO 32
`define BZM_BASE_HI 64

// ==========================================================
// register indexes (the address on the bus is the index itself)
`define BZM_IDX_A_PITCH_LO 16'hA040
`define BZM_IDX_A_PITCH_HI 16'hA041
`define BZM_IDX_A_LENGTH 16'hA042
`define BZM_IDX_A_GAP 16'hA043
`define BZM_IDX_B_PITCH_LO 16'hA044
`define BZM_IDX_B_PITCH_HI 16'hA045
`define BZM_IDX_B_LENGTH 16'hA046
`define BZM_IDX_B_GAP 16'hA047
`define BZM_IDX_CONFIG 16'hA048
`define BZM_IDX_WIN_LENGTH 16'hA049
`define BZM_IDX_TIMEBASE 16'hA04A
`define BZM_IDX_MELODY_CTRL 16'hA04B
`define BZM_IDX_IRQ_STATUS 16'hA04C
`define BZM_IDX_IRQ_MASK 16'hA04D
`define BZM_RST_VAL 8'h00

// ==========================================================
// beeper_config fields
`define BZM_CFG_EN 7
`define BZM_CFG_POL 6
`define BZM_CFG_IENB 5
`define BZM_CFG_IENA 4
`define BZM_CFG_FLGB 3
`define BZM_CFG_FLGA 2
`define BZM_CFG_CMDB 1
`define BZM_CFG_CMDA 0

// ==========================================================
// note_timebase, melody control and irq fields
`define BZM_TB_TU_HI 7
`define BZM_TB_TU_LO 6
`define BZM_TB_BASE 4
`define BZM_TB_WIEN 1
`define BZM_TB_WFLG 0
`define BZM_MC_PINGPONG 0
`define BZM_IRQ_A 0
`define BZM_IRQ_B 1
`define BZM_IRQ_WIN 2

`endif

// [bzm_pkg.sv]
// types shared by the buzzer and melody tone generator.
// assumes nothing of its surroundings.
package bzm_pkg;

  // ==========================================================
  // playback states, gray along idle -> tone -> gap
  typedef enum logic [1:0] {
    BZM_IDLE = 2'b00,
    BZM_TONE = 2'b01,
    BZM_GAP = 2'b11
  } bzm_state_e;

endpackage : bzm_pkg

// [bzm_tick_gen.sv]
// time unit tick generator: one pulse every 1, 2, 4 or 8 ms.
// assumes clear_i is on the same clock; held high, it keeps the tick off.
`timescale 1ns/10ps
`include "bzm_params.svh"
module bzm_tick_gen import bzm_pkg::*; #(
  parameter int CYC_PER_MS = `BZM_CYC_PER_MS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // control
  input wire logic clear_i,
  input wire logic [1:0] tu_sel_i,
  // tick
  output logic tick_o
);
  localparam int W = (CYC_PER_MS > 1) ? $clog2(CYC_PER_MS) : 1;
  localparam logic [W-1:0] LAST = W'(CYC_PER_MS - 1);

  logic [W-1:0] ms_q, ms_d;
  logic [2:0] unit_q, unit_d, unit_lim;
  logic tick_q, tick_d;

  // ==========================================================
  // millisecond prescaler and unit multiplier
  always_comb begin
    unique case (tu_sel_i)
      2'b00: unit_lim = 3'h0;
      2'b01: unit_lim = 3'h1;
      2'b10: unit_lim = 3'h3;
      2'b11: unit_lim = 3'h7;
    endcase
    ms_d = (ms_q == LAST) ? '0 : ms_q + W'(1);
    unit_d = unit_q;
    tick_d = 1'b0;
    if (ms_q == LAST) begin
      unit_d = (unit_q >= unit_lim) ? 3'h0 : unit_q + 3'h1;
      tick_d = (unit_q >= unit_lim);
    end
    // restart so a note's first unit is a whole unit long
    if (clear_i) begin
      ms_d = '0;
      unit_d = 3'h0;
      tick_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ms_q <= '0;
      unit_q <= 3'h0;
      tick_q <= 1'b0;
    end else begin
      ms_q <= ms_d;
      unit_q <= unit_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;

endmodule : bzm_tick_gen

// [bzm_tone_div.sv]
// tone divider: square wave at clock / base / (pitch + 1).
// assumes run_i is low outside a sounding note; low run resets the wave.
`timescale 1ns/10ps
`include "bzm_params.svh"
module bzm_tone_div import bzm_pkg::*; #(
  parameter int PW = 12
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // control
  input wire logic run_i,
  input wire logic base_sel_i,
  input wire logic [PW-1:0] pitch_i,
  // wave
  output logic wave_o
);
  // the wave toggles twice a period, so each half runs on half the base
  localparam logic [5:0] PRE_LO = 6'(`BZM_BASE_LO / 2 - 1);
  localparam logic [5:0] PRE_HI = 6'(`BZM_BASE_HI / 2 - 1);

  logic [5:0] pre_q, pre_d;
  logic [PW-1:0] div_q, div_d;
  logic wave_q, wave_d;
  logic pre_wrap;

  // ==========================================================
  // base prescaler then pitch divider
  always_comb begin
    pre_wrap = (pre_q == (base_sel_i ? PRE_HI : PRE_LO));
    pre_d = pre_wrap ? 6'h00 : pre_q + 6'h01;
    div_d = div_q;
    wave_d = wave_q;
    if (pre_wrap) begin
      div_d = (div_q >= pitch_i) ? '0 : div_q + PW'(1);
      if (div_q >= pitch_i) begin
        wave_d = ~wave_q;
      end
    end
    if (!run_i) begin
      pre_d = 6'h00;
      div_d = '0;
      wave_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pre_q <= 6'h00;
      div_q <= '0;
      wave_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      div_q <= div_d;
      wave_q <= wave_d;
    end
  end

  assign wave_o = wave_q;

endmodule : bzm_tone_div

// [bzm_buzzer_model.sv]
// behavioural buzzer element with its power switch, watching the beeper pin.
// assumes the pin and the power control are registered outputs on clk_i.
`timescale 1ns/10ps
module bzm_buzzer_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // buzzer side
  input wire logic beeper_pin_i,
  input wire logic power_en_i,
  // measurements
  output int half_period_o,
  output int toggle_count_o,
  output int power_cycles_o
);
  logic last_q;
  int run_q;

  // ==========================================================
  // element: a half period is the run of clocks between two edges
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      last_q <= 1'b0;
      run_q <= 0;
      half_period_o <= 0;
      toggle_count_o <= 0;
      power_cycles_o <= 0;
    end else begin
      last_q <= beeper_pin_i;
      if (beeper_pin_i !== last_q) begin
        half_period_o <= run_q;
        run_q <= 1;
        toggle_count_o <= toggle_count_o + 1;
      end else begin
        run_q <= run_q + 1;
      end
      // power switch closed only on a clean high
      if (power_en_i === 1'b1) begin
        power_cycles_o <= power_cycles_o + 1;
      end
    end
  end
endmodule : bzm_buzzer_model

// [buzzer_melody_tone_generator_bench.sv]
// self-checking bench of the buzzer and melody tone generator.
// assumes bzm_top with a shortened millisecond count and the buzzer model.
`timescale 1ns/10ps
`include "bzm_params.svh"
module buzzer_melody_tone_generator_bench;
  localparam int UNIT = 20;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h00000000;
  logic [31:0] rdata;
  logic wreq, pin, win, irq;
  int half, togs, pcyc, t0, dur, i, k, p, b, n0;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int seed = 96;
  logic [7:0] q, d;

  bzm_top #(.CYC_PER_MS(UNIT)) dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .beeper_pin_o(pin),
    .drive_window_o(win), .irq_o(irq));
  bzm_buzzer_model buzzer (.clk_i(clk_i), .reset_n_i(reset_n_i), .beeper_pin_i(pin),
    .power_en_i(win), .half_period_o(half), .toggle_count_o(togs), .power_cycles_o(pcyc));

  initial forever #25 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;

  // ==========================================================
  // checking and closing
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test

  function automatic int note_cycles(int len, int gap, int tu);
    return ((len + gap) * UNIT) << tu;
  endfunction : note_cycles

  function automatic int half_exp(int base_hi, int pitch);
    return (base_hi ? `BZM_BASE_HI / 2 : `BZM_BASE_LO / 2) * (pitch + 1);
  endfunction : half_exp

  // ==========================================================
  // avalon-mm master: request held until waitrequest is sampled low
  task xfer(input logic w, input logic [15:0] a, input logic [7:0] dat);
    int n;
    n = 0;
    @(posedge clk_i);
    adr <= a;
    rd <= !w;
    wr <= w;
    wd <= {24'h000000, dat};
    @(posedge clk_i);
    while (wreq !== 1'b0 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 20) begin
      fail_count++;
      $display("mismatch at %0t: bus never answered", $time);
    end
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : xfer

  // start a note and poll until both busy bits drop; dur in clocks
  task play(input logic [7:0] cmd);
    int n;
    n = 0;
    t0 = cyc;
    xfer(1'b1, `BZM_IDX_CONFIG, cmd);
    q = 8'h01;
    while (q[1:0] !== 2'b00 && n < 3000) begin
      xfer(1'b0, `BZM_IDX_CONFIG, 8'h00);
      n++;
    end
    dur = cyc - t0;
  endtask : play

  task set_note(input logic [15:0] base, input logic [11:0] pd, input logic [7:0] ln,
      input logic [7:0] gp);
    xfer(1'b1, base, pd[7:0]);
    xfer(1'b1, base + 16'h0001, {4'h0, pd[11:8]});
    xfer(1'b1, base + 16'h0002, ln);
    xfer(1'b1, base + 16'h0003, gp);
  endtask : set_note

  initial begin
    #(40000 * 50);
    fail_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_of_test;
  end

  // ==========================================================
  // tests
  initial begin
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (i = 0; i < 14; i++) begin
      xfer(1'b0, `BZM_IDX_A_PITCH_LO + i[15:0], 8'h00);
      check(q, `BZM_RST_VAL);
    end
    xfer(1'b1, 16'h0100, 8'h5A);
    xfer(1'b0, 16'h0100, 8'h00);
    check(q, 8'h00);
    $display("test reset_values done");
    for (i = 0; i < 10; i++) begin
      k = (i == 8) ? 9 : i;
      d = $random(seed);
      if (k == 1 || k == 5) d = d & 8'h0F;
      xfer(1'b1, `BZM_IDX_A_PITCH_LO + k[15:0], d);
      xfer(1'b0, `BZM_IDX_A_PITCH_LO + k[15:0], 8'h00);
      check(q, d);
    end
    $display("test read_write done");
    // every time unit code scales tone and gap
    set_note(`BZM_IDX_A_PITCH_LO, 12'h000, 8'h01, 8'h01);
    for (k = 0; k < 4; k++) begin
      xfer(1'b1, `BZM_IDX_TIMEBASE, {k[1:0], 6'h00});
      play(8'h81);
      check((dur >= note_cycles(1, 1, k)) && (dur <= note_cycles(1, 1, k) + 12), 1);
    end
    $display("test time_unit done");
    // tone frequency for random pitch and base
    for (k = 0; k < 4; k++) begin
      p = $random(seed) & 3;
      b = $random(seed) & 1;
      set_note(`BZM_IDX_A_PITCH_LO, p[11:0], 8'd30, 8'h00);
      xfer(1'b1, `BZM_IDX_TIMEBASE, {3'h0, b[0], 4'h0});
      n0 = togs;
      xfer(1'b1, `BZM_IDX_CONFIG, 8'h81);
      for (i = 0; i < 2000 && togs < n0 + 3; i++) @(posedge clk_i);
      check(half, half_exp(b, p));
      play(8'h80);
      check(pin, 1'b0);
    end
    $display("test tone_pitch done");
    // both started: A then B, flags, interrupt
    set_note(`BZM_IDX_A_PITCH_LO, 12'h001, 8'h02, 8'h01);
    set_note(`BZM_IDX_B_PITCH_LO, 12'h002, 8'h01, 8'h01);
    xfer(1'b1, `BZM_IDX_TIMEBASE, 8'h00);
    xfer(1'b1, `BZM_IDX_CONFIG, 8'hB3);
    xfer(1'b0, `BZM_IDX_CONFIG, 8'h00);
    check(q[1:0], 2'b01);
    for (i = 0; i < 200 && q[1] !== 1'b1; i++) xfer(1'b0, `BZM_IDX_CONFIG, 8'h00);
    check(q[1:0], 2'b10);
    // ones in the flag bits keep note a's flag while b plays
    play(8'hBC);
    check(q, 8'hBC);
    xfer(1'b1, `BZM_IDX_IRQ_MASK, 8'h03);
    // a write lands at the edge that ends the transfer: let it settle
    @(posedge clk_i);
    check(irq, 1'b1);
    xfer(1'b1, `BZM_IDX_IRQ_STATUS, 8'h01);
    @(posedge clk_i);
    check(irq, 1'b1);
    xfer(1'b1, `BZM_IDX_CONFIG, 8'hB8);
    xfer(1'b0, `BZM_IDX_CONFIG, 8'h00);
    check(q, 8'hB8);
    xfer(1'b1, `BZM_IDX_IRQ_STATUS, 8'h02);
    @(posedge clk_i);
    check(irq, 1'b0);
    // disable so no window left running leaks into the next count
    xfer(1'b1, `BZM_IDX_CONFIG, 8'h00);
    $display("test sequence_flags done");
    // drive window length and expiry flag
    xfer(1'b1, `BZM_IDX_WIN_LENGTH, 8'h03);
    xfer(1'b1, `BZM_IDX_TIMEBASE, 8'h02);
    set_note(`BZM_IDX_A_PITCH_LO, 12'h000, 8'h05, 8'h00);
    n0 = pcyc;
    play(8'h81);
    check((pcyc - n0 >= 3 * UNIT) && (pcyc - n0 <= 3 * UNIT + 2), 1);
    xfer(1'b0, `BZM_IDX_TIMEBASE, 8'h00);
    check(q, 8'h03);
    xfer(1'b1, `BZM_IDX_IRQ_MASK, 8'h04);
    @(posedge clk_i);
    check(irq, 1'b1);
    xfer(1'b1, `BZM_IDX_TIMEBASE, 8'h02);
    xfer(1'b0, `BZM_IDX_TIMEBASE, 8'h00);
    check(q, 8'h02);
    xfer(1'b1, `BZM_IDX_IRQ_STATUS, 8'h04);
    @(posedge clk_i);
    check(irq, 1'b0);
    $display("test drive_window done");
    // disable in mid-note with inverted polarity
    set_note(`BZM_IDX_A_PITCH_LO, 12'h000, 8'd50, 8'h00);
    xfer(1'b1, `BZM_IDX_CONFIG, 8'hC1);
    repeat (30) @(posedge clk_i);
    xfer(1'b1, `BZM_IDX_CONFIG, 8'h40);
    repeat (4) @(posedge clk_i);
    check(pin, 1'b1);
    xfer(1'b0, `BZM_IDX_CONFIG, 8'h00);
    check(q, 8'h40);
    xfer(1'b1, `BZM_IDX_CONFIG, 8'h00);
    repeat (2) @(posedge clk_i);
    check(pin, 1'b0);
    $display("test disable done");
    // ping-pong: finishing A launches B
    set_note(`BZM_IDX_A_PITCH_LO, 12'h000, 8'h01, 8'h00);
    set_note(`BZM_IDX_B_PITCH_LO, 12'h000, 8'h01, 8'h00);
    xfer(1'b1, `BZM_IDX_MELODY_CTRL, 8'h01);
    xfer(1'b1, `BZM_IDX_CONFIG, 8'h81);
    q = 8'h00;
    for (i = 0; i < 100 && q[1] !== 1'b1; i++) xfer(1'b0, `BZM_IDX_CONFIG, 8'h00);
    check(q[1], 1'b1);
    xfer(1'b1, `BZM_IDX_CONFIG, 8'h00);
    xfer(1'b1, `BZM_IDX_MELODY_CTRL, 8'h00);
    $display("test ping_pong done");
    end_of_test;
  end
endmodule : buzzer_melody_tone_generator_bench
